// ### verilog/ump_pkg.sv
package ump_pkg;
	// ********************************
	// Register map
	// ********************************
	localparam logic [7:0] UMP_CTRL_ADDR = 8'h98;
	localparam logic [7:0] UMP_DATA_ADDR = 8'h99;
	localparam logic [7:0] UMP_CTRL_RESET = 8'h40;
	localparam int UMP_MODE_BIT = 7;
	localparam int UMP_UNUSED_BIT = 6;
	localparam int UMP_MCE_BIT = 5;
	localparam int UMP_REN_BIT = 4;
	localparam int UMP_TB8_BIT = 3;
	localparam int UMP_RB8_BIT = 2;
	localparam int UMP_TI_BIT = 1;
	localparam int UMP_RI_BIT = 0;
	// ********************************
	// Baud timer and frame constants
	// ********************************
	localparam logic [5:0] UMP_PRE_DIV4 = 6'h04;
	localparam logic [5:0] UMP_PRE_DIV12 = 6'h0C;
	localparam logic [5:0] UMP_PRE_DIV48 = 6'h30;
	localparam logic [2:0] UMP_EXT_DIV_LAST = 3'h7;
	localparam logic [7:0] UMP_TIMER_TOP = 8'hFF;
	localparam logic [3:0] UMP_LAST_DATA8 = 4'h8;
	localparam logic [3:0] UMP_LAST_DATA9 = 4'h9;
	typedef enum logic [2:0] {UMP_SRC_SYS, UMP_SRC_DIV4, UMP_SRC_DIV12, UMP_SRC_DIV48, UMP_SRC_EXT8} ump_clk_src_t;
	typedef enum logic [1:0] {UMP_TX_IDLE, UMP_TX_WAIT, UMP_TX_SEND} ump_tx_state_t;
	typedef enum logic {UMP_RX_IDLE, UMP_RX_BITS} ump_rx_state_t;
endpackage

// ### verilog/ump_link_if.sv
`timescale 1ns/100ps
interface ump_link_if;
	logic dev_to_peer;
	logic peer_to_dev;
	modport device(output dev_to_peer, input peer_to_dev);
	modport peer(input dev_to_peer, output peer_to_dev);
endinterface

// ### verilog/ump_uart_dev.sv
`timescale 1ns/100ps
// How it works
// - 8-bit frame: start, 8 data LSB first, stop
// - 9-bit frame adds ninth bit from control
// - Control bit 7 selects 8 or 9-bit
// - Only data buffer write starts transmission
// - Transmit flag set at stop bit start
// - Receive only while receive enable is set
// - 8-bit load: flag clear, stop checked optionally
// - Failed conditions: buffer, ninth, flag untouched
// - 9-bit: ignore stop, filter on ninth bit
// - Overrun keeps first byte, drops next frame
// - Flags cleared only by software writes
// - Interrupt when enabled and any flag set
// - Receive shifter separate from receive buffer
// - Transmit timer plus hidden receive timer copy
// - Overflows halved to make bit rate
// - Start edge reloads hidden receive timer
// - Five selectable baud timer clock sources
// - Control bit 6 reads one, ignores writes
// - One data address: read rx, write tx
// - Master sends address with ninth bit one
// - Receive flag set when stop sampled
module ump_uart_dev
	import ump_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic timer_run,
	input wire logic [7:0] baud_timer_reload,
	input wire ump_clk_src_t timer_clk_sel,
	input wire logic ext_osc_clk,
	input wire logic irq_enable,
	output logic irq,
	ump_link_if.device link
);
	// ********************************
	// State
	// ********************************
	typedef struct packed {
		logic frame_mode_select;
		logic multiprocessor_check_enable;
		logic receive_enable_bit;
		logic ninth_transmit_bit;
		logic ninth_received_bit;
		logic transmit_complete_flag;
		logic receive_done_flag;
		logic [7:0] rx_buf;
		logic [7:0] rdata;
		logic irq;
		logic [5:0] pre_cnt;
		logic ext_s1;
		logic ext_s2;
		logic ext_prev;
		logic [2:0] ext_cnt;
		logic [7:0] baud_timer_low_count;
		logic tx_half;
		logic [7:0] rx_tl;
		logic rx_half;
		ump_tx_state_t tx_state;
		logic [9:0] tx_shift;
		logic [3:0] tx_cnt;
		logic tx_line;
		logic rx_s1;
		logic rx_s2;
		logic rx_prev;
		ump_rx_state_t rx_state;
		logic [8:0] rx_shift;
		logic [3:0] rx_cnt;
	} ump_dev_st_t;

	ump_dev_st_t st_r;
	ump_dev_st_t st_nxt;

	logic ext_tick;
	logic timer_tick;
	logic tx_ovf;
	logic rx_ovf;
	logic tx_baud;
	logic rx_sample;
	logic [3:0] last_data;
	logic [7:0] rx_data;
	logic rx_ninth;
	logic rx_accept;
	logic ctrl_wr;
	logic data_wr;

	always_comb begin
		st_nxt = st_r;
		ctrl_wr = sfr_wr && (sfr_addr == UMP_CTRL_ADDR);
		data_wr = sfr_wr && (sfr_addr == UMP_DATA_ADDR);
		// ********************************
		// Baud timer clock source
		// ********************************
		// Prescaler wraps at the largest divisor so every ratio shares one counter
		st_nxt.pre_cnt = (st_r.pre_cnt == UMP_PRE_DIV48 - 6'h01) ? 6'h00 : st_r.pre_cnt + 6'h01;
		st_nxt.ext_s1 = ext_osc_clk;
		st_nxt.ext_s2 = st_r.ext_s1;
		st_nxt.ext_prev = st_r.ext_s2;
		ext_tick = 1'b0;
		if (st_r.ext_s2 && !st_r.ext_prev) begin
			st_nxt.ext_cnt = st_r.ext_cnt + 3'h1;
			ext_tick = (st_r.ext_cnt == UMP_EXT_DIV_LAST);
		end
		unique case (timer_clk_sel)
			UMP_SRC_SYS: timer_tick = 1'b1;
			UMP_SRC_DIV4: timer_tick = (st_r.pre_cnt % UMP_PRE_DIV4) == UMP_PRE_DIV4 - 6'h01;
			UMP_SRC_DIV12: timer_tick = (st_r.pre_cnt % UMP_PRE_DIV12) == UMP_PRE_DIV12 - 6'h01;
			UMP_SRC_DIV48: timer_tick = st_r.pre_cnt == UMP_PRE_DIV48 - 6'h01;
			UMP_SRC_EXT8: timer_tick = ext_tick;
			default: timer_tick = 1'b0;
		endcase
		timer_tick = timer_tick && timer_run;
		// ********************************
		// Transmit and hidden receive timers
		// ********************************
		tx_ovf = timer_tick && (st_r.baud_timer_low_count == UMP_TIMER_TOP);
		rx_ovf = timer_tick && (st_r.rx_tl == UMP_TIMER_TOP);
		if (timer_tick) begin
			st_nxt.baud_timer_low_count = tx_ovf ? baud_timer_reload : st_r.baud_timer_low_count + 8'h01;
			st_nxt.rx_tl = rx_ovf ? baud_timer_reload : st_r.rx_tl + 8'h01;
		end
		if (tx_ovf)
			st_nxt.tx_half = !st_r.tx_half;
		if (rx_ovf)
			st_nxt.rx_half = !st_r.rx_half;
		tx_baud = tx_ovf && st_r.tx_half;
		// First overflow after a start reload is mid start bit, then every second one
		rx_sample = rx_ovf && !st_r.rx_half;
		last_data = st_r.frame_mode_select ? UMP_LAST_DATA9 : UMP_LAST_DATA8;
		// ********************************
		// Register writes
		// ********************************
		if (ctrl_wr) begin
			st_nxt.frame_mode_select = sfr_wdata[UMP_MODE_BIT];
			st_nxt.multiprocessor_check_enable = sfr_wdata[UMP_MCE_BIT];
			st_nxt.receive_enable_bit = sfr_wdata[UMP_REN_BIT];
			st_nxt.ninth_transmit_bit = sfr_wdata[UMP_TB8_BIT];
			st_nxt.ninth_received_bit = sfr_wdata[UMP_RB8_BIT];
			st_nxt.transmit_complete_flag = sfr_wdata[UMP_TI_BIT];
			st_nxt.receive_done_flag = sfr_wdata[UMP_RI_BIT];
		end
		// ********************************
		// Transmitter
		// ********************************
		unique case (st_r.tx_state)
			UMP_TX_IDLE: begin
				st_nxt.tx_line = 1'b1;
				// Writes while busy are dropped; the shifter holds the frame in flight
				if (data_wr) begin
					st_nxt.tx_shift = {1'b1, st_r.frame_mode_select ? st_r.ninth_transmit_bit : 1'b1, sfr_wdata};
					st_nxt.tx_state = UMP_TX_WAIT;
				end
			end
			UMP_TX_WAIT: begin
				if (tx_baud) begin
					st_nxt.tx_line = 1'b0;
					st_nxt.tx_cnt = 4'h0;
					st_nxt.tx_state = UMP_TX_SEND;
				end
			end
			UMP_TX_SEND: begin
				if (tx_baud) begin
					if (st_r.tx_cnt == last_data + 4'h1) begin
						st_nxt.tx_state = UMP_TX_IDLE;
					end else begin
						st_nxt.tx_line = st_r.tx_shift[0];
						st_nxt.tx_shift = {1'b1, st_r.tx_shift[9:1]};
						st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
						if (st_r.tx_cnt == last_data)
							st_nxt.transmit_complete_flag = 1'b1;
					end
				end
			end
			default: st_nxt.tx_state = UMP_TX_IDLE;
		endcase
		// ********************************
		// Receiver
		// ********************************
		st_nxt.rx_s1 = link.peer_to_dev;
		st_nxt.rx_s2 = st_r.rx_s1;
		st_nxt.rx_prev = st_r.rx_s2;
		rx_data = st_r.frame_mode_select ? st_r.rx_shift[7:0] : st_r.rx_shift[8:1];
		rx_ninth = st_r.frame_mode_select ? st_r.rx_shift[8] : st_r.rx_s2;
		rx_accept = !st_r.receive_done_flag && (!st_r.multiprocessor_check_enable || rx_ninth);
		unique case (st_r.rx_state)
			UMP_RX_IDLE: begin
				if (st_r.receive_enable_bit && timer_run && st_r.rx_prev && !st_r.rx_s2) begin
					st_nxt.rx_tl = baud_timer_reload;
					st_nxt.rx_half = 1'b0;
					st_nxt.rx_cnt = 4'h0;
					st_nxt.rx_state = UMP_RX_BITS;
				end
			end
			UMP_RX_BITS: begin
				if (!st_r.receive_enable_bit) begin
					st_nxt.rx_state = UMP_RX_IDLE;
				end else if (rx_sample) begin
					st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
					if (st_r.rx_cnt == 4'h0) begin
						if (st_r.rx_s2)
							st_nxt.rx_state = UMP_RX_IDLE;
					end else if (st_r.rx_cnt <= last_data) begin
						st_nxt.rx_shift = {st_r.rx_s2, st_r.rx_shift[8:1]};
					end else begin
						st_nxt.rx_state = UMP_RX_IDLE;
						// A full buffer or a filtered frame leaves everything as it was
						if (rx_accept) begin
							st_nxt.rx_buf = rx_data;
							st_nxt.ninth_received_bit = rx_ninth;
							st_nxt.receive_done_flag = 1'b1;
						end
					end
				end
			end
		endcase
		// ********************************
		// Read port and interrupt
		// ********************************
		if (sfr_rd) begin
			if (sfr_addr == UMP_CTRL_ADDR)
				st_nxt.rdata = {st_r.frame_mode_select, 1'b1, st_r.multiprocessor_check_enable,
					st_r.receive_enable_bit, st_r.ninth_transmit_bit, st_r.ninth_received_bit,
					st_r.transmit_complete_flag, st_r.receive_done_flag};
			else if (sfr_addr == UMP_DATA_ADDR)
				st_nxt.rdata = st_r.rx_buf;
			else
				st_nxt.rdata = 8'h00;
		end
		st_nxt.irq = irq_enable && (st_nxt.transmit_complete_flag || st_nxt.receive_done_flag);
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
			st_r.tx_line <= 1'b1;
			st_r.rx_s1 <= 1'b1;
			st_r.rx_s2 <= 1'b1;
			st_r.rx_prev <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sfr_rdata = st_r.rdata;
	assign irq = st_r.irq;
	assign link.dev_to_peer = st_r.tx_line;
endmodule

// ### verilog/ump_peer_node.sv
`timescale 1ns/100ps
module ump_peer_node
	import ump_pkg::*;
#(
	parameter int CNT_W = 16
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic nine_bit_mode,
	input wire logic [CNT_W-1:0] bit_cycles,
	input wire logic send_valid,
	input wire logic [7:0] send_data,
	input wire logic send_ninth,
	output logic send_ready,
	output logic recv_valid,
	output logic [7:0] recv_data,
	output logic recv_ninth,
	output logic recv_stop_ok,
	ump_link_if.peer link
);
	// Bit timer needs room for a half-bit count
	if (CNT_W < 2) begin : g_cnt_w_check
		$error("CNT_W must be at least 2");
	end

	// ********************************
	// State
	// ********************************
	typedef struct packed {
		ump_tx_state_t tx_state;
		logic [9:0] tx_shift;
		logic [3:0] tx_cnt;
		logic [CNT_W-1:0] tx_tmr;
		logic tx_line;
		logic ready;
		logic rx_s1;
		logic rx_s2;
		logic rx_prev;
		ump_rx_state_t rx_state;
		logic [CNT_W-1:0] rx_tmr;
		logic [3:0] rx_cnt;
		logic [9:0] rx_shift;
		logic rvalid;
		logic [7:0] rdata;
		logic rninth;
		logic rstop;
	} ump_peer_st_t;

	ump_peer_st_t st_r;
	ump_peer_st_t st_nxt;
	logic [3:0] last_bit;
	logic [9:0] rx_v;

	always_comb begin
		st_nxt = st_r;
		st_nxt.rvalid = 1'b0;
		// Bits after the start bit, stop bit included
		last_bit = (nine_bit_mode ? UMP_LAST_DATA9 : UMP_LAST_DATA8) + 4'h1;
		// ********************************
		// Transmitter
		// ********************************
		unique case (st_r.tx_state)
			UMP_TX_IDLE: begin
				st_nxt.tx_line = 1'b1;
				if (send_valid && st_r.ready) begin
					// Address frames carry a one in the ninth bit, data frames a zero
					st_nxt.tx_shift = {1'b1, nine_bit_mode ? send_ninth : 1'b1, send_data};
					st_nxt.tx_line = 1'b0;
					st_nxt.tx_cnt = 4'h0;
					st_nxt.tx_tmr = bit_cycles - CNT_W'(1);
					st_nxt.ready = 1'b0;
					st_nxt.tx_state = UMP_TX_SEND;
				end
			end
			UMP_TX_SEND: begin
				if (st_r.tx_tmr != '0) begin
					st_nxt.tx_tmr = st_r.tx_tmr - CNT_W'(1);
				end else if (st_r.tx_cnt == last_bit) begin
					st_nxt.ready = 1'b1;
					st_nxt.tx_state = UMP_TX_IDLE;
				end else begin
					st_nxt.tx_line = st_r.tx_shift[0];
					st_nxt.tx_shift = {1'b1, st_r.tx_shift[9:1]};
					st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
					st_nxt.tx_tmr = bit_cycles - CNT_W'(1);
				end
			end
			default: st_nxt.tx_state = UMP_TX_IDLE;
		endcase
		// ********************************
		// Receiver
		// ********************************
		st_nxt.rx_s1 = link.dev_to_peer;
		st_nxt.rx_s2 = st_r.rx_s1;
		st_nxt.rx_prev = st_r.rx_s2;
		rx_v = {st_r.rx_s2, st_r.rx_shift[9:1]};
		unique case (st_r.rx_state)
			UMP_RX_IDLE: begin
				if (st_r.rx_prev && !st_r.rx_s2) begin
					st_nxt.rx_tmr = bit_cycles >> 1;
					st_nxt.rx_cnt = 4'h0;
					st_nxt.rx_state = UMP_RX_BITS;
				end
			end
			UMP_RX_BITS: begin
				if (st_r.rx_tmr != '0) begin
					st_nxt.rx_tmr = st_r.rx_tmr - CNT_W'(1);
				end else begin
					st_nxt.rx_tmr = bit_cycles - CNT_W'(1);
					st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
					if (st_r.rx_cnt == 4'h0) begin
						if (st_r.rx_s2)
							st_nxt.rx_state = UMP_RX_IDLE;
					end else begin
						st_nxt.rx_shift = rx_v;
						if (st_r.rx_cnt == last_bit) begin
							st_nxt.rx_state = UMP_RX_IDLE;
							st_nxt.rvalid = 1'b1;
							st_nxt.rdata = nine_bit_mode ? rx_v[7:0] : rx_v[8:1];
							st_nxt.rninth = nine_bit_mode ? rx_v[8] : rx_v[9];
							st_nxt.rstop = rx_v[9];
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
			st_r.tx_line <= 1'b1;
			st_r.ready <= 1'b1;
			st_r.rx_s1 <= 1'b1;
			st_r.rx_s2 <= 1'b1;
			st_r.rx_prev <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign send_ready = st_r.ready;
	assign recv_valid = st_r.rvalid;
	assign recv_data = st_r.rdata;
	assign recv_ninth = st_r.rninth;
	assign recv_stop_ok = st_r.rstop;
	assign link.peer_to_dev = st_r.tx_line;
endmodule

// ### tb/ump_link_assertions.sv
`timescale 1ns/100ps
module ump_link_assertions (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic dev_to_peer,
	input wire logic peer_to_dev,
	input wire logic irq,
	input wire logic irq_enable,
	input wire logic recv_valid,
	input wire logic recv_stop_ok,
	input wire logic send_ready
);
	// ****
	// Low run counters
	// ****
	// Two bits suffice: every bit time used here is a multiple of four clocks
	logic [1:0] tx_low_r;
	logic [1:0] rx_low_r;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_low_r <= 2'h0;
			rx_low_r <= 2'h0;
		end else begin
			tx_low_r <= dev_to_peer ? 2'h0 : tx_low_r + 2'h1;
			rx_low_r <= peer_to_dev ? 2'h0 : rx_low_r + 2'h1;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// ****
	// Checks
	// ****
	AST_IDLE_AT_RELEASE: assert property ($rose(reset_n) |-> dev_to_peer && peer_to_dev)
		else $error("line not idle high after reset");
	AST_TX_START_BIT: assert property ($fell(dev_to_peer) |-> !dev_to_peer [*4])
		else $error("device start bit too short");
	AST_TX_BIT_GRID: assert property ($rose(dev_to_peer) |-> tx_low_r == 2'h0)
		else $error("device low run off the bit grid");
	AST_RX_BIT_GRID: assert property ($rose(peer_to_dev) |-> rx_low_r == 2'h0)
		else $error("peer low run off the bit grid");
	AST_STOP_HIGH: assert property (recv_valid |-> recv_stop_ok)
		else $error("device frame without high stop bit");
	AST_IRQ_GATED: assert property (!$past(irq_enable) |-> !irq)
		else $error("interrupt raised while disabled");
	AST_RECV_PULSE: assert property (recv_valid |=> !recv_valid)
		else $error("receive pulse longer than one cycle");
	AST_PEER_START: assert property ($fell(send_ready) |-> !peer_to_dev)
		else $error("peer start bit missing");
	COV_RECV: cover property (recv_valid);
	COV_IRQ: cover property ($rose(irq));
	COV_TX: cover property ($fell(dev_to_peer));
endmodule

// ### tb/uart_8_9bit_multiproc_tb_top.sv
`timescale 1ns/100ps
module uart_8_9bit_multiproc_tb_top;
	import ump_pkg::*;
	logic clock, reset_n, sfr_wr, sfr_rd, timer_run, ext_osc_clk, irq_enable, irq;
	logic nine_bit_mode, send_valid, send_ninth, send_ready, recv_valid, recv_ninth, recv_stop_ok, eb;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, baud_timer_reload, send_data, recv_data, rv, ed;
	logic [15:0] bit_cycles;
	logic [31:0] seed;
	ump_clk_src_t timer_clk_sel;
	int bad_count, checks_done, i, k;
	ump_link_if link_inst();
	ump_uart_dev ump_uart_dev_inst(.clock(clock), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_run(timer_run),
		.baud_timer_reload(baud_timer_reload), .timer_clk_sel(timer_clk_sel), .ext_osc_clk(ext_osc_clk),
		.irq_enable(irq_enable), .irq(irq), .link(link_inst.device));
	ump_peer_node #(.CNT_W(16)) ump_peer_node_inst(.clock(clock), .reset_n(reset_n),
		.nine_bit_mode(nine_bit_mode), .bit_cycles(bit_cycles), .send_valid(send_valid), .send_data(send_data),
		.send_ninth(send_ninth), .send_ready(send_ready), .recv_valid(recv_valid), .recv_data(recv_data),
		.recv_ninth(recv_ninth), .recv_stop_ok(recv_stop_ok), .link(link_inst.peer));
	ump_link_assertions ump_link_assertions_inst(.clock(clock), .reset_n(reset_n),
		.dev_to_peer(link_inst.dev_to_peer), .peer_to_dev(link_inst.peer_to_dev), .irq(irq),
		.irq_enable(irq_enable), .recv_valid(recv_valid), .recv_stop_ok(recv_stop_ok), .send_ready(send_ready));
	// ****
	// Helpers
	// ****
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	function automatic logic exp_load(input logic mode, mce, stp, nin, ri);
		return !ri && (!mce || (mode ? nin : stp));
	endfunction
	task close_out();
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clock);
		sfr_wr = 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(negedge clock);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clock);
		sfr_rd = 1'b0;
		rv = sfr_rdata;
	endtask
	// Device sends, peer receives; 8-bit ninth is the stop bit
	task dsend(input logic [7:0] d, input logic n);
		wr(UMP_DATA_ADDR, d);
		for (k = 0; k < 4000 && recv_valid !== 1'b1; k++) begin
			@(posedge clock);
			#1;
		end
		chk("peer valid", 8'h01, {7'h00, recv_valid});
		chk("peer data", d, recv_data);
		chk("peer ninth", {7'h00, n}, {7'h00, recv_ninth});
		repeat (bit_cycles) @(negedge clock);
	endtask
	// Peer sends with control c already applied, device filters
	task prx(input logic [7:0] d, input logic n, input logic [7:0] c);
		logic e;
		wr(UMP_CTRL_ADDR, c);
		nine_bit_mode = c[7];
		send_data = d;
		send_ninth = n;
		send_valid = 1'b1;
		@(negedge clock);
		send_valid = 1'b0;
		for (k = 0; k < 4000 && send_ready !== 1'b1; k++)
			@(negedge clock);
		repeat (8) @(negedge clock);
		e = exp_load(c[7], c[5], 1'b1, n, c[0]) && c[4];
		// The control write itself sets the ninth bit field when no frame loads
		eb = c[UMP_RB8_BIT];
		if (e) begin
			ed = d;
			eb = c[7] ? n : 1'b1;
		end
		rd(UMP_CTRL_ADDR);
		chk("rx flag", {7'h00, e | c[0]}, {7'h00, rv[UMP_RI_BIT]});
		chk("rx ninth", {7'h00, eb}, {7'h00, rv[UMP_RB8_BIT]});
		rd(UMP_DATA_ADDR);
		chk("rx data", ed, rv);
	endtask
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		ext_osc_clk = 1'b0;
		forever #50 ext_osc_clk = ~ext_osc_clk;
	end
	initial begin
		#3000000;
		bad_count++;
		close_out();
	end
	// ****
	// Main sequence
	// ****
	initial begin
		{reset_n, sfr_wr, sfr_rd, irq_enable, nine_bit_mode, send_valid, send_ninth, eb} = 8'h00;
		{sfr_addr, sfr_wdata, send_data, ed} = 32'h00000000;
		timer_run = 1'b1;
		baud_timer_reload = 8'hFE;
		timer_clk_sel = UMP_SRC_SYS;
		bit_cycles = 16'h0004;
		seed = 32'h00007A97;
		repeat (3) @(negedge clock);
		reset_n = 1'b1;
		rd(UMP_CTRL_ADDR);
		chk("ctrl reset", UMP_CTRL_RESET, rv);
		wr(UMP_CTRL_ADDR, 8'h10);
		rd(UMP_CTRL_ADDR);
		chk("ctrl bit6", 8'h50, rv);
		rd(8'h50);
		chk("unmapped", 8'h00, rv);
		for (i = 0; i < 6; i++) begin
			seed = xs(seed);
			dsend(i == 0 ? 8'h00 : i == 1 ? 8'hFF : seed[7:0], 1'b1);
		end
		rd(UMP_CTRL_ADDR);
		chk("tx flag", 8'h52, rv);
		irq_enable = 1'b1;
		repeat (2) @(negedge clock);
		chk("irq on", 8'h01, {7'h00, irq});
		wr(UMP_CTRL_ADDR, 8'h10);
		@(negedge clock);
		chk("irq off", 8'h00, {7'h00, irq});
		for (i = 0; i < 2; i++) begin
			wr(UMP_CTRL_ADDR, i ? 8'h98 : 8'h90);
			nine_bit_mode = 1'b1;
			seed = xs(seed);
			dsend(seed[7:0], i[0]);
		end
		seed = xs(seed);
		prx(seed[7:0], 1'b0, 8'h90);
		prx(seed[15:8], 1'b1, 8'h91);
		prx(seed[23:16], 1'b0, 8'hB0);
		prx(seed[31:24], 1'b1, 8'hB0);
		prx(8'hA5, 1'b0, 8'h30);
		prx(8'h5A, 1'b0, 8'h00);
		// Peer rate tracks each timer clock source
		for (i = 0; i < 5; i++) begin
			timer_clk_sel = ump_clk_src_t'(i);
			bit_cycles = i == 0 ? 16'h0004 : i == 1 ? 16'h0010 : i == 2 ? 16'h0030 : i == 3 ? 16'h00C0 : 16'h0040;
			wr(UMP_CTRL_ADDR, 8'h10);
			nine_bit_mode = 1'b0;
			seed = xs(seed);
			dsend(seed[7:0], 1'b1);
			prx(seed[15:8], 1'b0, 8'h10);
		end
		close_out();
	end
endmodule
